// ==== src/scs_conv_clock.sv ====
`timescale 1ns/10ps
`default_nettype none
module scs_conv_clock (
  input wire logic i_clock,
  input wire logic i_rstn,
  scs_core_if.timer core
);

  // ----------------------------------------------------------------
  // internal conversion clock, independent of the serial clock
  // ----------------------------------------------------------------
  logic [scs_pkg::CONV_CNT_W-1:0] count;
  logic [scs_pkg::CONV_CNT_W-1:0] next_count;

  always_comb begin
    next_count = '0;
    if (core.run && count != scs_pkg::CONV_LAST) begin
      next_count = count + 3'h1;
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign core.tick = core.run && count == scs_pkg::CONV_LAST; // see RQ5

  property p_tick_spacing;
    @(posedge i_clock) disable iff (!i_rstn)
      core.tick |=> !core.tick;
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("conversion ticks back to back"); // see RQ5

endmodule // scs_conv_clock
`default_nettype wire

// ==== src/scs_core_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface scs_core_if;
  logic capture;
  logic run;
  logic tick;
  logic signed [scs_pkg::UV_W:0] held_diff;
  logic [scs_pkg::UV_W-1:0] held_vref;

  modport ctrl (output capture, output run, input tick, input held_diff, input held_vref);
  modport hold (input capture, input run, output held_diff, output held_vref);
  modport timer (input run, output tick);
endinterface
`default_nettype wire

// ==== src/scs_pkg.sv ====
package scs_pkg;

  // ----------------------------------------------------------------
  // widths and codes
  // ----------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int UV_W = 24;
  localparam int CMP_W = 50;
  localparam logic [3:0] MSB_INDEX = 4'hF;
  localparam logic [15:0] OFFSET_FLIP = 16'h8000;
  localparam logic [15:0] CODE_MAX_POS = 16'h7FFF;
  localparam logic [15:0] CODE_MAX_NEG = 16'h8000;
  localparam logic [15:0] CODE_RESET = 16'h0000;
  localparam logic signed [17:0] CODE_MID = 18'sh08000;
  localparam logic signed [17:0] CODE_POS_FS = 18'sh08000;
  localparam logic signed [17:0] CODE_NEG_FS = 18'sh38000;

  // ----------------------------------------------------------------
  // full scale: 32768 codes, span compression scales by 4/5
  // ----------------------------------------------------------------
  localparam logic signed [CMP_W-1:0] CMP_FS_SCALE = 50'sh28000;
  localparam logic signed [CMP_W-1:0] WEIGHT_FULL = 50'sh5;
  localparam logic signed [CMP_W-1:0] WEIGHT_SPAN = 50'sh4;
  localparam logic [UV_W-1:0] OV_MARGIN_UV = 24'h061A80;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic SPAN_RESET = 1'b0;
  localparam logic FLAG_RESET = 1'b0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int CONV_CLOCK_PERIOD_NS = 50;
  localparam int CONV_DIV = (CONV_CLOCK_PERIOD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int CONV_CNT_W = 3;
  localparam logic [CONV_CNT_W-1:0] CONV_LAST = 3'(CONV_DIV - 1);
  localparam int CONV_STEPS = 16;
  localparam int CONV_CYCLES = CONV_STEPS * CONV_DIV;

  typedef enum logic {SCS_ACQUIRE, SCS_CONVERT} scs_state_t;

endpackage

// ==== src/scs_sample_hold.sv ====
`timescale 1ns/10ps
`default_nettype none
module scs_sample_hold (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic signed [scs_pkg::UV_W-1:0] i_in_pos_uv,
  input wire logic signed [scs_pkg::UV_W-1:0] i_in_neg_uv,
  input wire logic [scs_pkg::UV_W-1:0] i_vref_uv,
  scs_core_if.hold core,
  output logic o_positive_sample_ground_switch,
  output logic o_negative_sample_ground_switch
);

  // ----------------------------------------------------------------
  // hold the differential input at the end of acquisition
  // ----------------------------------------------------------------
  logic signed [scs_pkg::UV_W:0] held_diff;
  logic [scs_pkg::UV_W-1:0] held_vref;
  logic signed [scs_pkg::UV_W:0] next_held_diff;
  logic [scs_pkg::UV_W-1:0] next_held_vref;

  always_comb begin
    next_held_diff = held_diff;
    next_held_vref = held_vref;
    if (core.capture) begin
      next_held_diff = (scs_pkg::UV_W+1)'(i_in_pos_uv) - (scs_pkg::UV_W+1)'(i_in_neg_uv); // see RQ1
      next_held_vref = i_vref_uv;
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      held_diff <= '0;
      held_vref <= '0;
    end else begin
      held_diff <= next_held_diff;
      held_vref <= next_held_vref;
    end
  end

  assign core.held_diff = held_diff;
  assign core.held_vref = held_vref;
  // switches closed during acquisition, opened first at conversion start
  assign o_positive_sample_ground_switch = !core.run;
  assign o_negative_sample_ground_switch = !core.run;

endmodule // scs_sample_hold
`default_nettype wire

// ==== src/scs_sequencer.sv ====
// Summary of operation
// RQ1: convert the held input, not live input
// RQ2: conversion start rising edge begins conversion
// RQ3: sixteen halving trial steps, MSB first
// RQ4: present code and busy end after steps
// RQ5: conversion timed by internal conversion clock
// RQ6: result is two's complement, midscale zero
// RQ7: above positive full scale gives 0x7FFF
// RQ8: below negative full scale gives 0x8000
// RQ9: span compression maps codes onto 0.8 span
// RQ10: clamp engages 0.4 V above reference
// RQ11: engaged clamp sets overvoltage flag
// RQ12: flag stays set until host reads
// RQ13: clamp also reported in data status bit
// RQ14: span compression off after reset
// RQ15: after completion, return to acquisition
`timescale 1ns/10ps
`default_nettype none
module scs_sequencer (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_conversion_start_input,
  input wire logic signed [scs_pkg::UV_W-1:0] i_in_pos_uv,
  input wire logic signed [scs_pkg::UV_W-1:0] i_in_neg_uv,
  input wire logic [scs_pkg::UV_W-1:0] i_vref_uv,
  input wire logic i_span_write,
  input wire logic i_span_value,
  input wire logic i_flag_read,
  output logic o_busy,
  output logic o_done,
  output logic [scs_pkg::DATA_W-1:0] o_result,
  output logic o_status_ov,
  output logic o_overvoltage_clamp_flag,
  output logic o_clamp_active,
  output logic o_span_enable,
  output logic o_positive_sample_ground_switch,
  output logic o_negative_sample_ground_switch
);

  // ----------------------------------------------------------------
  // comparator decision: is the trial level at or below the input
  // ----------------------------------------------------------------
  function automatic logic trial_le(
    input logic signed [17:0] code,
    input logic signed [scs_pkg::UV_W:0] diff,
    input logic [scs_pkg::UV_W-1:0] vref,
    input logic span
  );
    logic signed [scs_pkg::CMP_W-1:0] lhs;
    logic signed [scs_pkg::CMP_W-1:0] rhs;
    logic signed [scs_pkg::CMP_W-1:0] weight;
    weight = span ? scs_pkg::WEIGHT_SPAN : scs_pkg::WEIGHT_FULL; // see RQ9
    lhs = scs_pkg::CMP_W'(code) * scs_pkg::CMP_W'($signed({1'b0, vref})) * weight;
    rhs = scs_pkg::CMP_W'(diff) * scs_pkg::CMP_FS_SCALE;
    return lhs <= rhs;
  endfunction

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  scs_core_if core ();

  scs_conv_clock u_conv_clock (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .core(core)
  );

  scs_sample_hold u_sample_hold (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_in_pos_uv(i_in_pos_uv),
    .i_in_neg_uv(i_in_neg_uv),
    .i_vref_uv(i_vref_uv),
    .core(core),
    .o_positive_sample_ground_switch(o_positive_sample_ground_switch),
    .o_negative_sample_ground_switch(o_negative_sample_ground_switch)
  );

  // ----------------------------------------------------------------
  // start edge, span control and clamp detect
  // ----------------------------------------------------------------
  scs_pkg::scs_state_t state;
  scs_pkg::scs_state_t next_state;
  logic start_prev;
  logic span_enable;
  logic next_span_enable;
  logic conv_span;
  logic next_conv_span;
  logic start_rise;
  logic clamp_now;
  logic signed [scs_pkg::UV_W+1:0] clamp_limit;

  assign start_rise = i_conversion_start_input && !start_prev; // see RQ2
  assign clamp_limit = (scs_pkg::UV_W+2)'($signed({1'b0, i_vref_uv})) +
                       (scs_pkg::UV_W+2)'($signed({1'b0, scs_pkg::OV_MARGIN_UV}));
  // a pin at exactly the limit is not yet clamped
  assign clamp_now = (scs_pkg::UV_W+2)'(i_in_pos_uv) > clamp_limit ||
                     (scs_pkg::UV_W+2)'(i_in_neg_uv) > clamp_limit; // see RQ10

  always_comb begin
    next_span_enable = span_enable;
    if (i_span_write) begin
      next_span_enable = i_span_value; // see RQ14
    end
    // span is frozen per conversion so a mid-conversion write cannot split a result
    next_conv_span = conv_span;
    if (start_rise && state == scs_pkg::SCS_ACQUIRE) begin
      next_conv_span = span_enable;
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      start_prev <= 1'b0;
      span_enable <= scs_pkg::SPAN_RESET; // see RQ14
      conv_span <= scs_pkg::SPAN_RESET;
    end else begin
      start_prev <= i_conversion_start_input;
      span_enable <= next_span_enable;
      conv_span <= next_conv_span;
    end
  end

  // ----------------------------------------------------------------
  // successive approximation state machine
  // ----------------------------------------------------------------
  logic [scs_pkg::DATA_W-1:0] sar_code;
  logic [scs_pkg::DATA_W-1:0] next_sar_code;
  logic [3:0] bit_idx;
  logic [3:0] next_bit_idx;
  logic [scs_pkg::DATA_W-1:0] trial;
  logic keep;
  logic [scs_pkg::DATA_W-1:0] final_code;
  logic over_range;
  logic under_range;
  logic [scs_pkg::DATA_W-1:0] result;
  logic [scs_pkg::DATA_W-1:0] next_result;
  logic done;
  logic next_done;
  logic ov_seen;
  logic next_ov_seen;
  logic status_ov;
  logic next_status_ov;
  logic flag;
  logic next_flag;

  assign trial = sar_code | (16'h0001 << bit_idx); // see RQ3
  assign keep = trial_le(18'($signed({2'b00, trial})) - scs_pkg::CODE_MID,
                         core.held_diff, core.held_vref, conv_span); // see RQ1
  assign final_code = keep ? trial : sar_code;
  assign over_range = trial_le(scs_pkg::CODE_POS_FS, core.held_diff, core.held_vref, conv_span);
  assign under_range = !trial_le(scs_pkg::CODE_NEG_FS, core.held_diff, core.held_vref, conv_span);

  assign core.capture = start_rise && state == scs_pkg::SCS_ACQUIRE; // see RQ1
  assign core.run = state == scs_pkg::SCS_CONVERT;

  always_comb begin
    next_state = state;
    next_sar_code = sar_code;
    next_bit_idx = bit_idx;
    next_result = result;
    next_done = 1'b0;
    next_status_ov = status_ov;
    next_ov_seen = ov_seen | clamp_now;
    unique case (state)
      scs_pkg::SCS_ACQUIRE: begin
        // a start edge during conversion is ignored: only acquisition listens
        if (start_rise) begin
          next_state = scs_pkg::SCS_CONVERT; // see RQ2
          next_sar_code = '0;
          next_bit_idx = scs_pkg::MSB_INDEX; // see RQ3
          next_ov_seen = clamp_now;
        end
      end
      scs_pkg::SCS_CONVERT: begin
        if (core.tick) begin // see RQ5
          next_sar_code = final_code;
          next_bit_idx = bit_idx - 4'h1; // see RQ3
          if (bit_idx == 4'h0) begin
            next_state = scs_pkg::SCS_ACQUIRE; // see RQ15
            next_done = 1'b1; // see RQ4
            next_status_ov = ov_seen | clamp_now | flag; // see RQ13
            if (over_range) begin
              next_result = scs_pkg::CODE_MAX_POS; // see RQ7
            end else if (under_range) begin
              next_result = scs_pkg::CODE_MAX_NEG; // see RQ8
            end else begin
              next_result = final_code ^ scs_pkg::OFFSET_FLIP; // see RQ6
            end
          end
        end
      end
    endcase
    // set wins over a read in the same cycle
    next_flag = clamp_now | (flag & !i_flag_read); // see RQ11 see RQ12
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= scs_pkg::SCS_ACQUIRE;
      sar_code <= '0;
      bit_idx <= scs_pkg::MSB_INDEX;
      result <= scs_pkg::CODE_RESET;
      done <= 1'b0;
      ov_seen <= 1'b0;
      status_ov <= 1'b0;
      flag <= scs_pkg::FLAG_RESET;
    end else begin
      state <= next_state;
      sar_code <= next_sar_code;
      bit_idx <= next_bit_idx;
      result <= next_result;
      done <= next_done;
      ov_seen <= next_ov_seen;
      status_ov <= next_status_ov;
      flag <= next_flag;
    end
  end

  assign o_busy = state == scs_pkg::SCS_CONVERT; // see RQ4
  assign o_done = done;
  assign o_result = result;
  assign o_status_ov = status_ov;
  assign o_overvoltage_clamp_flag = flag;
  assign o_clamp_active = clamp_now;
  assign o_span_enable = span_enable;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [7:0] busy_len;

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      busy_len <= 8'h00;
    end else if (o_busy) begin
      busy_len <= busy_len + 8'h01;
    end else begin
      busy_len <= 8'h00;
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);

  sequence s_start;
    !o_busy && start_rise;
  endsequence

  sequence s_finish;
    $fell(o_busy) && o_done;
  endsequence

  property p_start;
    s_start |=> o_busy && !o_positive_sample_ground_switch && bit_idx == 4'hF;
  endproperty
  a_start: assert property (p_start) else $error("start edge did not begin conversion"); // see RQ2

  property p_hold;
    o_busy && $past(o_busy) |-> $stable(core.held_diff) && $stable(core.held_vref);
  endproperty
  a_hold: assert property (p_hold) else $error("held input moved during conversion"); // see RQ1

  property p_step;
    o_busy && core.tick && bit_idx != 4'h0 |=> bit_idx == $past(bit_idx) - 4'h1;
  endproperty
  a_step: assert property (p_step) else $error("trial step did not halve"); // see RQ3

  property p_length;
    $fell(o_busy) |-> $past(busy_len) == 8'(scs_pkg::CONV_CYCLES - 1);
  endproperty
  a_length: assert property (p_length) else $error("conversion length wrong"); // see RQ5

  property p_finish;
    $fell(o_busy) |-> s_finish ##1 (!o_done && o_positive_sample_ground_switch);
  endproperty
  a_finish: assert property (p_finish) else $error("end of conversion not signalled"); // see RQ4 see RQ15

  property p_mid;
    s_finish and (core.held_diff == '0) |-> o_result == 16'h0000;
  endproperty
  a_mid: assert property (p_mid) else $error("midscale code wrong"); // see RQ6

  property p_over;
    s_finish and (over_range) |-> o_result == 16'h7FFF;
  endproperty
  a_over: assert property (p_over) else $error("over-range not saturated"); // see RQ7

  property p_under;
    s_finish and (under_range) |-> o_result == 16'h8000;
  endproperty
  a_under: assert property (p_under) else $error("under-range not saturated"); // see RQ8

  property p_flag_set;
    clamp_now |=> o_overvoltage_clamp_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("clamp did not set flag"); // see RQ11

  property p_flag_sticky;
    o_overvoltage_clamp_flag && !i_flag_read |=> o_overvoltage_clamp_flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped without read"); // see RQ12

  property p_flag_clear;
    o_overvoltage_clamp_flag && i_flag_read && !clamp_now |=> !o_overvoltage_clamp_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag read did not clear"); // see RQ12

  property p_status;
    o_busy && clamp_now |-> ##[1:80] (o_done && o_status_ov);
  endproperty
  a_status: assert property (p_status) else $error("status bit missed clamp"); // see RQ13

endmodule // scs_sequencer
`default_nettype wire

// ==== verif/scs_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module scs_host_model (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_busy,
  output logic o_start,
  output logic o_flag_read
);
  // ----------------------------------------------------------------
  // host side of conversion start and flag readout
  // ----------------------------------------------------------------
  initial begin
    o_start = 1'b0;
    o_flag_read = 1'b0;
  end

  // start held until busy is seen, so a slow edge is never lost
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_start <= 1'b0;
    end else if (o_start && i_busy) begin
      o_start <= 1'b0;
    end
  end

  // raise start at the current rising edge
  task automatic request();
    o_start <= 1'b1;
  endtask

  // one-cycle read of the sticky flag
  task automatic read_flag();
    @(posedge i_clock);
    o_flag_read <= 1'b1;
    @(posedge i_clock);
    o_flag_read <= 1'b0;
  endtask
endmodule // scs_host_model
`default_nettype wire

// ==== verif/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic i_clock;
  logic i_rstn;
  logic start;
  logic flag_read;
  logic signed [scs_pkg::UV_W-1:0] in_pos;
  logic signed [scs_pkg::UV_W-1:0] in_neg;
  logic [scs_pkg::UV_W-1:0] vref;
  logic span_write;
  logic span_value;
  logic busy;
  logic done;
  logic [scs_pkg::DATA_W-1:0] result;
  logic status_ov;
  logic ov_flag;
  logic clamp_active;
  logic span_enable;
  logic sw_pos;
  logic sw_neg;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;

  scs_sequencer u_scs_sequencer (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_conversion_start_input(start),
    .i_in_pos_uv(in_pos), .i_in_neg_uv(in_neg), .i_vref_uv(vref),
    .i_span_write(span_write), .i_span_value(span_value), .i_flag_read(flag_read),
    .o_busy(busy), .o_done(done), .o_result(result), .o_status_ov(status_ov),
    .o_overvoltage_clamp_flag(ov_flag), .o_clamp_active(clamp_active), .o_span_enable(span_enable),
    .o_positive_sample_ground_switch(sw_pos), .o_negative_sample_ground_switch(sw_neg)
  );

  scs_host_model u_scs_host_model (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_busy(busy), .o_start(start), .o_flag_read(flag_read)
  );

  // ----------------------------------------------------------------
  // clock, timeout, verdict
  // ----------------------------------------------------------------
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  // about 2100 cycles are needed; the margin covers slow handshakes
  always @(posedge i_clock) begin
    cycles = cycles + 1;
    if (cycles == 10000) begin
      num_errors = num_errors + 1;
      stop_test();
    end
  end

  task automatic stop_test();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // compares
  // ----------------------------------------------------------------
  task automatic check_bit(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic check_code(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic check_count(input int got, input int exp, input string what);
    samples_checked++;
    if (got != exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // shared steps
  // ----------------------------------------------------------------
  // live input is moved after the start edge; result must not follow it
  task automatic do_conv(input longint pos_uv, input longint neg_uv, input logic [15:0] exp,
                         input logic exp_ov, input bit poke);
    int cnt;
    int wait_n;
    @(posedge i_clock);
    in_pos <= 24'(pos_uv);
    in_neg <= 24'(neg_uv);
    @(posedge i_clock);
    u_scs_host_model.request();
    wait_n = 0;
    do begin
      @(posedge i_clock);
      #1;
      wait_n++;
    end while (busy !== 1'b1 && wait_n < 4);
    check_bit(busy, 1'b1, "busy after start");
    check_bit(sw_pos, 1'b0, "pos switch open");
    check_bit(sw_neg, 1'b0, "neg switch open");
    cnt = 0;
    while (busy === 1'b1 && cnt < 200) begin
      @(posedge i_clock);
      if (cnt == 0) begin
        in_pos <= 24'h12D687;
        in_neg <= 24'h000000;
      end
      if (cnt == 40 && poke) begin
        u_scs_host_model.request();
      end
      #1;
      cnt++;
    end
    check_count(cnt, scs_pkg::CONV_CYCLES, "busy length");
    check_bit(done, 1'b1, "done with busy end");
    check_code(result, exp, "result");
    check_bit(status_ov, exp_ov, "status ov");
    check_bit(sw_pos, 1'b1, "back to acquire");
    @(posedge i_clock);
    #1;
    check_bit(done, 1'b0, "done one cycle");
    check_bit(busy, 1'b0, "start in busy ignored");
  endtask

  task automatic set_span(input logic v);
    @(posedge i_clock);
    span_write <= 1'b1;
    span_value <= v;
    @(posedge i_clock);
    span_write <= 1'b0;
    #1;
    check_bit(span_enable, v, "span write");
  endtask

  task automatic run_table(input longint d[10], input logic [15:0] c[10]);
    for (int i = 0; i < 10; i++) begin
      do_conv((d[i] > 0) ? d[i] : 0, (d[i] < 0) ? -d[i] : 0, c[i], 1'b0, 1'b0);
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_reset();
    check_bit(busy, 1'b0, "reset busy");
    check_bit(done, 1'b0, "reset done");
    check_code(result, 16'h0000, "reset result");
    check_bit(ov_flag, 1'b0, "reset flag");
    check_bit(span_enable, 1'b0, "reset span");
    check_bit(sw_pos, 1'b1, "reset switch");
  endtask

  task automatic test_full_codes();
    run_table('{0, 153, -1, 4999900, -5000000, 5000001, -5000001, 2500000, -2500000, 3333283},
              '{16'h0000, 16'h0001, 16'hFFFF, 16'h7FFF, 16'h8000, 16'h7FFF, 16'h8000, 16'h4000,
                16'hC000, 16'h5555});
  endtask

  task automatic test_span_codes();
    set_span(1'b1);
    run_table('{123, 244, -123, 3999900, 4000000, 4500000, -4000000, -4000001, 2000000, -1},
              '{16'h0001, 16'h0001, 16'hFFFE, 16'h7FFF, 16'h7FFF, 16'h7FFF, 16'h8000, 16'h8000,
                16'h4000, 16'hFFFF});
    set_span(1'b0);
    do_conv(4500000, 0, 16'h7333, 1'b0, 1'b0);
  endtask

  task automatic test_back_to_back();
    do_conv(1000000, 0, 16'h1999, 1'b0, 1'b1);
    do_conv(0, 1000000, 16'hE666, 1'b0, 1'b1);
  endtask

  task automatic test_flag();
    @(posedge i_clock);
    in_pos <= 24'h5265C0;
    in_neg <= 24'h000000;
    @(posedge i_clock);
    #1;
    check_bit(clamp_active, 1'b0, "clamp at threshold");
    @(posedge i_clock);
    in_pos <= 24'h5265C1;
    #1;
    check_bit(ov_flag, 1'b0, "no flag at threshold");
    check_bit(clamp_active, 1'b1, "clamp above threshold");
    @(posedge i_clock);
    #1;
    check_bit(ov_flag, 1'b1, "flag set");
    u_scs_host_model.read_flag();
    #1;
    check_bit(ov_flag, 1'b1, "read while clamped");
    do_conv(0, 5400001, 16'h8000, 1'b1, 1'b0);
    repeat (3) @(posedge i_clock);
    #1;
    check_bit(ov_flag, 1'b1, "flag sticky");
    u_scs_host_model.read_flag();
    #1;
    check_bit(ov_flag, 1'b0, "flag read clears");
    do_conv(0, 0, 16'h0000, 1'b0, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    i_rstn = 1'b0;
    in_pos = 24'h000000;
    in_neg = 24'h000000;
    vref = 24'h4C4B40;
    span_write = 1'b0;
    span_value = 1'b0;
    repeat (16) @(posedge i_clock);
    i_rstn <= 1'b1;
    #1;
    test_reset();
    test_full_codes();
    test_span_codes();
    test_back_to_back();
    test_flag();
    stop_test();
  end
endmodule // tb
`default_nettype wire
